// ### udpc_ctrl.v
// USB device profile selection, boot enumeration and power control
// Contract
// R1 - Disable USB on low after VBUS falling edge
// R2 - Run link as high-speed 480 Mb/s
// R3 - Device role only; host enumerates
// R4 - Default profile: one RNDIS, one ACM
// R5 - Each profile has distinct VID/PID pair
// R6 - Exactly one profile active at once
// R7 - Six-ACM profile selectable
// R8 - ECM plus three ACM profile selectable
// R9 - Profile choice applies from next reboot
// R10 - Boot first shows empty interim profile
// R11 - Selected profile about 20 s later
// R12 - Suspend after bus idle with power saving
// R13 - Keep address and configuration while suspended
// R14 - Suspend when upstream hub port disabled
// R15 - Resume on any bus activity
// R16 - Active mode while attached and not suspended
// R17 - Signal remote wake-up from suspend
// R18 - Synchronise VBUS sense before edge detect
`timescale 1ns/100ps
`default_nettype none
`include "udpc_defs.vh"
module udpc_ctrl #(
    parameter INTERIM_CYC = `UDPC_INTERIM_CYC,
    parameter IDLE_CYC = `UDPC_IDLE_CYC,
    parameter WAKE_CYC = `UDPC_WAKE_CYC,
    parameter WAKE_WAIT_CYC = `UDPC_WAKE_WAIT_CYC,
    parameter [15:0] VENDOR_ID = 16'hA5A5,
    parameter [15:0] PID_DEFAULT = 16'h0101,
    parameter [15:0] PID_ACM6 = 16'h0102,
    parameter [15:0] PID_ECM4 = 16'h0103,
    parameter [15:0] PID_INTERIM = 16'h0100
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    // Non-volatile profile store
    input wire nv_valid_i,
    input wire [1:0] nv_profile_i,
    output wire [1:0] nv_profile_o,
    output wire nv_write_o,
    input wire power_off_i,
    // Commands
    input wire profile_select_command_i,
    input wire [1:0] profile_select_value_i,
    input wire power_saving_command_i,
    input wire power_saving_enable_i,
    input wire wake_request_i,
    // Bus state from the line interface
    input wire vbus_sense_input_i,
    input wire bus_activity_i,
    input wire hub_port_disabled_i,
    input wire set_address_i,
    input wire [6:0] address_i,
    input wire set_config_i,
    input wire [7:0] config_i,
    // Received data stream into the device
    input wire rx_valid_i,
    output wire rx_ready_o,
    input wire [7:0] rx_data_i,
    output wire cmd_valid_o,
    input wire cmd_ready_i,
    output wire [7:0] cmd_data_o,
    // Link control
    output wire usb_enable_o,
    output wire soft_connect_o,
    output wire high_speed_o,
    output wire device_role_o,
    output wire remote_wake_o,
    output wire suspended_o,
    output wire usb_force_active_o,
    output wire other_power_save_o,
    // Descriptor and state view
    output wire [15:0] vendor_id_o,
    output wire [15:0] product_id_o,
    output wire [1:0] active_profile_o,
    output wire [3:0] func_count_o,
    output wire [4:0] func_class_o,
    output wire [6:0] address_o,
    output wire [7:0] config_o
);
    // States
    localparam [4:0] ST_OFF = 5'h01;
    localparam [4:0] ST_INTERIM = 5'h02;
    localparam [4:0] ST_RECON = 5'h04;
    localparam [4:0] ST_ACTIVE = 5'h08;
    localparam [4:0] ST_SUSP = 5'h10;

    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg [31:0] tmr_r;
    reg [31:0] tmr_nxt;
    reg [1:0] boot_prof_r;
    reg [1:0] pend_prof_r;
    reg pend_dirty_r;
    reg [1:0] act_prof_r;
    reg [1:0] act_prof_nxt;
    reg psv_r;
    reg vbus_d_r;
    reg detached_r;
    reg strap_done_r;
    reg [6:0] addr_r;
    reg [7:0] cfg_r;
    reg wake_r;
    reg wake_nxt;
    reg [31:0] susp_tmr_r;
    reg nv_wr_r;
    reg [15:0] pid_r;
    reg [3:0] nfunc_r;
    reg [4:0] fclass_r;
    wire vbus_s;
    wire vbus_fall;
    wire fifo_in_ready;

    udpc_sync2 u_vbus_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .d_i(vbus_sense_input_i),
        .q_o(vbus_s)
    ); // [R18]

    assign vbus_fall = vbus_d_r & ~vbus_s; // [R18]

    // Profile store; boot profile caught after reset release
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            strap_done_r <= 1'b0;
            boot_prof_r <= `UDPC_PROF_DEFAULT;
            pend_prof_r <= `UDPC_PROF_DEFAULT;
            pend_dirty_r <= 1'b0;
            nv_wr_r <= 1'b0;
            psv_r <= 1'b0;
        end else begin
            nv_wr_r <= 1'b0;
            if (!strap_done_r) begin
                strap_done_r <= 1'b1;
                if (nv_valid_i && nv_profile_i != `UDPC_PROF_INTERIM) begin
                    boot_prof_r <= nv_profile_i;
                    pend_prof_r <= nv_profile_i;
                end else begin
                    boot_prof_r <= `UDPC_PROF_DEFAULT; // [R4]
                    pend_prof_r <= `UDPC_PROF_DEFAULT;
                end
            end else if (profile_select_command_i &&
                         profile_select_value_i != `UDPC_PROF_INTERIM) begin
                pend_prof_r <= profile_select_value_i; // [R9]
                pend_dirty_r <= 1'b1;
            end else if (power_off_i && pend_dirty_r) begin
                nv_wr_r <= 1'b1; // [R9]
                pend_dirty_r <= 1'b0;
            end
            if (power_saving_command_i) begin
                psv_r <= power_saving_enable_i;
            end
        end
    end

    // Detach tracking
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            vbus_d_r <= 1'b0;
            detached_r <= 1'b0;
        end else begin
            vbus_d_r <= vbus_s;
            if (vbus_fall) begin
                detached_r <= 1'b1; // [R1]
            end else if (vbus_s) begin
                detached_r <= 1'b0;
            end
        end
    end

    // Main sequence
    always @* begin
        state_nxt = state_r;
        tmr_nxt = tmr_r;
        act_prof_nxt = act_prof_r;
        wake_nxt = 1'b0;
        case (state_r)
            ST_OFF: begin
                tmr_nxt = 32'h0;
                if (strap_done_r && vbus_s) begin
                    state_nxt = ST_INTERIM;
                    act_prof_nxt = `UDPC_PROF_INTERIM; // [R10]
                end
            end
            ST_INTERIM: begin
                tmr_nxt = tmr_r + 32'h1;
                if (tmr_r >= INTERIM_CYC - 1) begin
                    state_nxt = ST_RECON; // [R11]
                    tmr_nxt = 32'h0;
                end
            end
            ST_RECON: begin
                act_prof_nxt = boot_prof_r; // [R11] [R5]
                state_nxt = ST_ACTIVE;
            end
            ST_ACTIVE: begin
                tmr_nxt = bus_activity_i ? 32'h0 : tmr_r + 32'h1;
                if (hub_port_disabled_i) begin
                    state_nxt = ST_SUSP; // [R14]
                    tmr_nxt = 32'h0;
                end else if (psv_r && tmr_r >= IDLE_CYC - 1) begin
                    state_nxt = ST_SUSP; // [R12]
                    tmr_nxt = 32'h0;
                end
            end
            ST_SUSP: begin
                if (bus_activity_i && !wake_r) begin
                    state_nxt = ST_ACTIVE; // [R15]
                    tmr_nxt = 32'h0;
                end else if (wake_r) begin
                    tmr_nxt = tmr_r + 32'h1;
                    wake_nxt = 1'b1;
                    if (tmr_r >= WAKE_CYC - 1) begin
                        state_nxt = ST_ACTIVE; // [R17]
                        tmr_nxt = 32'h0;
                        wake_nxt = 1'b0;
                    end
                end else if (wake_request_i && susp_tmr_r >= WAKE_WAIT_CYC - 1) begin
                    wake_nxt = 1'b1; // [R17]
                    tmr_nxt = 32'h0;
                end
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
        if (detached_r && state_r != ST_OFF) begin
            state_nxt = ST_OFF; // [R1]
            tmr_nxt = 32'h0;
            wake_nxt = 1'b0;
        end
    end

    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_r <= ST_OFF;
            tmr_r <= 32'h0;
            act_prof_r <= `UDPC_PROF_INTERIM;
            wake_r <= 1'b0;
            susp_tmr_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
            act_prof_r <= act_prof_nxt; // [R6]
            wake_r <= wake_nxt;
            if (state_r == ST_SUSP) begin
                if (susp_tmr_r != 32'hFFFFFFFF) begin
                    susp_tmr_r <= susp_tmr_r + 32'h1;
                end
            end else begin
                susp_tmr_r <= 32'h0;
            end
        end
    end

    // Device state; kept through suspend, cleared only in ST_OFF and ST_RECON
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            addr_r <= 7'h00;
            cfg_r <= 8'h00;
        end else if (state_r == ST_OFF || state_r == ST_RECON) begin
            addr_r <= 7'h00;
            cfg_r <= 8'h00;
        end else if (state_r != ST_SUSP) begin // [R13]
            if (set_address_i) begin
                addr_r <= address_i;
            end
            if (set_config_i) begin
                cfg_r <= config_i;
            end
        end
    end

    // Descriptor identity per profile
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            pid_r <= PID_INTERIM;
            nfunc_r <= `UDPC_NFUNC_INTERIM;
            fclass_r <= 5'h00;
        end else begin
            case (act_prof_r)
                `UDPC_PROF_DEFAULT: begin
                    pid_r <= PID_DEFAULT; // [R5]
                    nfunc_r <= `UDPC_NFUNC_DEFAULT; // [R4]
                    fclass_r <= `UDPC_FN_RNDIS | `UDPC_FN_ACM;
                end
                `UDPC_PROF_ACM6: begin
                    pid_r <= PID_ACM6;
                    nfunc_r <= `UDPC_NFUNC_ACM6; // [R7]
                    fclass_r <= `UDPC_FN_ACM;
                end
                `UDPC_PROF_ECM4: begin
                    pid_r <= PID_ECM4;
                    nfunc_r <= `UDPC_NFUNC_ECM4; // [R8]
                    fclass_r <= `UDPC_FN_ECM | `UDPC_FN_ACM;
                end
                default: begin
                    pid_r <= PID_INTERIM;
                    nfunc_r <= `UDPC_NFUNC_INTERIM; // [R10]
                    fclass_r <= 5'h00;
                end
            endcase
        end
    end

    // Command stream; nothing is passed on under the interim profile
    udpc_fifo #(
        .WIDTH(`UDPC_FIFO_W),
        .DEPTH(`UDPC_FIFO_D),
        .AW(`UDPC_FIFO_AW)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .flush_i(state_r == ST_OFF),
        .in_valid_i(rx_valid_i && state_r == ST_ACTIVE),
        .in_ready_o(fifo_in_ready),
        .in_data_i(rx_data_i),
        .out_valid_o(cmd_valid_o),
        .out_ready_i(cmd_ready_i),
        .out_data_o(cmd_data_o)
    ); // [R10]
    assign rx_ready_o = fifo_in_ready & (state_r == ST_ACTIVE); // [R10]

    assign usb_enable_o = ~detached_r & (state_r != ST_OFF); // [R1]
    assign soft_connect_o = (state_r != ST_OFF) & (state_r != ST_RECON);
    assign high_speed_o = 1'b1; // [R2]
    assign device_role_o = 1'b1; // [R3]
    assign remote_wake_o = wake_r; // [R17]
    assign suspended_o = (state_r == ST_SUSP);
    assign usb_force_active_o = (state_r == ST_INTERIM) | (state_r == ST_ACTIVE)
        | (state_r == ST_RECON); // [R16]
    assign other_power_save_o = psv_r; // [R16]
    assign vendor_id_o = VENDOR_ID;
    assign product_id_o = pid_r;
    assign active_profile_o = act_prof_r;
    assign func_count_o = nfunc_r;
    assign func_class_o = fclass_r;
    assign address_o = addr_r;
    assign config_o = cfg_r;
    assign nv_profile_o = pend_prof_r;
    assign nv_write_o = nv_wr_r;
endmodule // udpc_ctrl
`default_nettype wire

// ### udpc_defs.vh
// Constants for the USB device profile and power control block
`ifndef UDPC_DEFS_VH
`define UDPC_DEFS_VH

// Clock
`define UDPC_CLK_MHZ 125
// Interim profile hold time, seconds
`define UDPC_INTERIM_S 20
`define UDPC_INTERIM_CYC (`UDPC_INTERIM_S * `UDPC_CLK_MHZ * 1000000)
// Bus idle before suspend, microseconds (3 ms)
`define UDPC_IDLE_US 3000
`define UDPC_IDLE_CYC (`UDPC_IDLE_US * `UDPC_CLK_MHZ)
// Remote wake-up K drive time, microseconds (least 1 ms)
`define UDPC_WAKE_US 1000
`define UDPC_WAKE_CYC (`UDPC_WAKE_US * `UDPC_CLK_MHZ)
// Least suspend time before remote wake-up may be signalled, microseconds
`define UDPC_WAKE_WAIT_US 5000
`define UDPC_WAKE_WAIT_CYC (`UDPC_WAKE_WAIT_US * `UDPC_CLK_MHZ)
// Line rate in Mb/s
`define UDPC_LINE_MBPS 480

// Profile codes
`define UDPC_PROF_W 2
`define UDPC_PROF_DEFAULT 2'h0
`define UDPC_PROF_ACM6 2'h1
`define UDPC_PROF_ECM4 2'h2
`define UDPC_PROF_INTERIM 2'h3

// Function counts per profile
`define UDPC_NFUNC_DEFAULT 4'h2
`define UDPC_NFUNC_ACM6 4'h6
`define UDPC_NFUNC_ECM4 4'h4
`define UDPC_NFUNC_INTERIM 4'h0

// Function class mask bits: acm, rndis, ecm, ncm, mbim
`define UDPC_FN_ACM 5'h01
`define UDPC_FN_RNDIS 5'h02
`define UDPC_FN_ECM 5'h04
`define UDPC_FN_NCM 5'h08
`define UDPC_FN_MBIM 5'h10

// FIFO
`define UDPC_FIFO_W 8
`define UDPC_FIFO_D 4
`define UDPC_FIFO_AW 2

`endif

// ### udpc_sync2.v
// Two-stage synchroniser for one level
`timescale 1ns/100ps
`default_nettype none
module udpc_sync2 (
    // Clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    // Data
    input wire d_i,
    output wire q_o
);
    reg meta_r;
    reg sync_r;
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= d_i;
            sync_r <= meta_r;
        end
    end
    assign q_o = sync_r;
endmodule // udpc_sync2
`default_nettype wire

// ### udpc_fifo.v
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module udpc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    input wire flush_i,
    // Write side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Read side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;
    assign in_ready_o = (cnt_r != DEPTH[AW:0]);
    assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
    assign out_data_o = mem_r[rd_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    always @(posedge sys_clk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end
    always @(posedge sys_clk_i) begin
        if (reset_i | flush_i) begin
            wr_r <= {AW{1'b0}};
            rd_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
            if (push & ~pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop & ~push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // udpc_fifo
`default_nettype wire

// ### udpc_ctrl_props.sv
// Assertion checker for the USB profile and power control block
`timescale 1ns/100ps
`default_nettype none
module udpc_ctrl_props #(
    parameter WAKE_CYC = 10,
    parameter [15:0] PID_DEFAULT = 16'h0101,
    parameter [15:0] PID_ACM6 = 16'h0102,
    parameter [15:0] PID_ECM4 = 16'h0103,
    parameter [15:0] PID_INTERIM = 16'h0100
) (
    // Clock, reset and requests
    input wire sys_clk_i, reset_i, profile_select_command_i, power_saving_command_i,
    input wire power_saving_enable_i, wake_request_i, vbus_sense_input_i,
    input wire bus_activity_i, hub_port_disabled_i,
    input wire [1:0] profile_select_value_i,
    // Observed outputs
    input wire usb_enable_o, soft_connect_o, high_speed_o, device_role_o, remote_wake_o,
    input wire suspended_o, other_power_save_o,
    input wire [1:0] nv_profile_o, active_profile_o,
    input wire [15:0] product_id_o,
    input wire [6:0] address_o,
    input wire [7:0] config_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    logic [15:0] wake_cnt_r;
    always @(posedge sys_clk_i) begin
        if (reset_i || !remote_wake_o) begin
            wake_cnt_r <= 16'h0000;
        end else begin
            wake_cnt_r <= wake_cnt_r + 16'h0001;
        end
    end
    function automatic logic [15:0] pid_of(input logic [1:0] p);
        return p == 2'h0 ? PID_DEFAULT : p == 2'h1 ? PID_ACM6 : p == 2'h2 ? PID_ECM4 : PID_INTERIM;
    endfunction
    sequence s_active;
        usb_enable_o && soft_connect_o && active_profile_o != 2'h3 && !suspended_o;
    endsequence
    sequence s_hub_drop;
        hub_port_disabled_i && !bus_activity_i && !remote_wake_o;
    endsequence
    AST_ROLE: assert property (high_speed_o && device_role_o)
        else $error("link not high-speed device");
    AST_DETACH: assert property (!vbus_sense_input_i [*5] |-> !usb_enable_o)
        else $error("usb still enabled after vbus low");
    AST_SEL: assert property (profile_select_command_i && profile_select_value_i != 2'h3
        |=> nv_profile_o == $past(profile_select_value_i))
        else $error("pending profile not taken");
    AST_SWITCH: assert property ($changed(active_profile_o) |-> !$past(soft_connect_o))
        else $error("profile changed while connected");
    AST_PID: assert property ($stable(active_profile_o)
        |-> product_id_o == pid_of(active_profile_o))
        else $error("product id does not match profile");
    AST_HUB: assert property (s_active ##0 s_hub_drop |=> suspended_o)
        else $error("no suspend on hub port disable");
    AST_RESUME: assert property (suspended_o && bus_activity_i && !remote_wake_o
        && !wake_request_i |=> !suspended_o)
        else $error("no resume on activity");
    AST_KEEP: assert property (suspended_o ##1 suspended_o
        |-> $stable(address_o) && $stable(config_o))
        else $error("state lost in suspend");
    AST_PWR: assert property (power_saving_command_i
        |=> other_power_save_o == $past(power_saving_enable_i))
        else $error("power saving setting not applied");
    AST_WAKE_FROM: assert property ($rose(remote_wake_o) |-> $past(suspended_o))
        else $error("wake signalled while not suspended");
    AST_WAKE_LEN: assert property ($fell(remote_wake_o) |-> wake_cnt_r == WAKE_CYC)
        else $error("wake signalling length wrong");
endmodule // udpc_ctrl_props
`default_nettype wire

// ### udpc_host_model.sv
// Host-side model that drives bus state into the control block
`timescale 1ns/100ps
`default_nettype none
module udpc_host_model (
    // Clock and device wake signalling
    input wire logic sys_clk_i,
    input wire logic remote_wake_i,
    // Bus state seen by the device
    output logic vbus_o, hub_o, set_addr_o, set_cfg_o,
    output logic act_o,
    output logic [6:0] addr_o,
    output logic [7:0] cfg_o
);
    logic traffic_r = 1'b0, resume_r = 1'b0, wake_d_r = 1'b0;
    initial begin
        {vbus_o, hub_o, set_addr_o, set_cfg_o} = 4'h0;
        addr_o = 7'h00;
        cfg_o = 8'h00;
    end
    // Resume traffic once the device ends its wake signalling
    always @(posedge sys_clk_i) begin
        wake_d_r <= remote_wake_i;
        resume_r <= wake_d_r & ~remote_wake_i;
    end
    assign act_o = traffic_r | resume_r;
    task attach(input logic v);
        @(negedge sys_clk_i);
        vbus_o = v;
    endtask
    task traffic(input logic v);
        @(negedge sys_clk_i);
        traffic_r = v;
    endtask
    task hub(input logic v);
        @(negedge sys_clk_i);
        hub_o = v;
    endtask
    // Host role: addresses and configures on the next clocks, with no wait for the final profile
    task enumerate(input logic [6:0] a, input logic [7:0] c);
        @(negedge sys_clk_i);
        set_addr_o = 1'b1;
        addr_o = a;
        @(negedge sys_clk_i);
        set_addr_o = 1'b0;
        addr_o = ~a;
        set_cfg_o = 1'b1;
        cfg_o = c;
        @(negedge sys_clk_i);
        set_cfg_o = 1'b0;
        cfg_o = ~c;
    endtask
endmodule // udpc_host_model
`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the USB profile and power control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam IC = 50, IDL = 20, WC = 10, WW = 10;
    logic sys_clk_i = 1'b0, reset_i = 1'b1, nv_valid_i = 1'b1, power_off_i = 1'b0;
    logic [1:0] nv_profile_i = 2'h0, psel_v = 2'h0;
    logic psel = 1'b0, ps_cmd = 1'b0, ps_en = 1'b0, wake_req = 1'b0;
    logic rx_valid_i = 1'b0, cmd_ready_i = 1'b0;
    logic [7:0] rx_data_i = 8'h00;
    wire vbus, act, hub, sa, sc, rx_ready_o, cmd_valid_o, usb_enable_o, soft_connect_o;
    wire nv_write_o, remote_wake_o, suspended_o, usb_force_active_o, other_power_save_o;
    wire high_speed_o, device_role_o;
    wire [6:0] addr, address_o;
    wire [7:0] cfg, config_o, cmd_data_o;
    wire [1:0] nv_profile_o, active_profile_o;
    wire [15:0] product_id_o, vendor_id_o;
    wire [3:0] func_count_o;
    wire [4:0] func_class_o;
    int n_errors = 0, check_count = 0, n, k;
    logic [31:0] seed, r;
    logic [7:0] q[$];
    always #4 sys_clk_i = ~sys_clk_i;
    udpc_ctrl #(.INTERIM_CYC(IC), .IDLE_CYC(IDL), .WAKE_CYC(WC), .WAKE_WAIT_CYC(WW)) i_udpc_ctrl (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .nv_valid_i(nv_valid_i),
        .nv_profile_i(nv_profile_i), .nv_profile_o(nv_profile_o), .nv_write_o(nv_write_o),
        .power_off_i(power_off_i), .profile_select_command_i(psel),
        .profile_select_value_i(psel_v), .power_saving_command_i(ps_cmd),
        .power_saving_enable_i(ps_en), .wake_request_i(wake_req), .vbus_sense_input_i(vbus),
        .bus_activity_i(act), .hub_port_disabled_i(hub), .set_address_i(sa), .address_i(addr),
        .set_config_i(sc), .config_i(cfg), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
        .rx_data_i(rx_data_i), .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
        .cmd_data_o(cmd_data_o), .usb_enable_o(usb_enable_o), .soft_connect_o(soft_connect_o),
        .high_speed_o(high_speed_o), .device_role_o(device_role_o),
        .remote_wake_o(remote_wake_o),
        .suspended_o(suspended_o), .usb_force_active_o(usb_force_active_o),
        .other_power_save_o(other_power_save_o), .vendor_id_o(vendor_id_o),
        .product_id_o(product_id_o),
        .active_profile_o(active_profile_o), .func_count_o(func_count_o),
        .func_class_o(func_class_o), .address_o(address_o), .config_o(config_o));
    udpc_host_model i_udpc_host_model (.sys_clk_i(sys_clk_i), .remote_wake_i(remote_wake_o),
        .vbus_o(vbus), .hub_o(hub), .set_addr_o(sa), .set_cfg_o(sc), .act_o(act),
        .addr_o(addr), .cfg_o(cfg));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic [24:0] exp_prof(input logic [1:0] p);
        case (p)
            2'h0: return {16'h0101, 4'h2, 5'h03};
            2'h1: return {16'h0102, 4'h6, 5'h01};
            default: return {16'h0103, 4'h4, 5'h05};
        endcase
    endfunction
    // Reboot with a stored profile, attach, follow the interim enumeration
    task boot(input logic [1:0] p, input logic v);
        reset_i = 1'b1;
        nv_profile_i = p;
        nv_valid_i = v;
        if (!v) p = 2'h0;
        i_udpc_host_model.attach(1'b0);
        repeat (2) @(negedge sys_clk_i);
        reset_i = 1'b0;
        i_udpc_host_model.attach(1'b1);
        n = 0;
        while (soft_connect_o !== 1'b1 && n < 10) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk(32'({active_profile_o, func_count_o}), 32'h30);
        n = 0;
        while (soft_connect_o === 1'b1 && n < 200) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk(32'(n), 32'(IC));
        repeat (2) @(negedge sys_clk_i);
        chk(32'({product_id_o, func_count_o, func_class_o}), 32'(exp_prof(p)));
        chk(32'({active_profile_o, soft_connect_o}), 32'({p, 1'b1}));
        chk(32'({high_speed_o, device_role_o, vendor_id_o}), 32'h3A5A5);
        $display("boot with profile %0d done", p);
    endtask
    task sel(input logic [1:0] v);
        @(negedge sys_clk_i);
        psel = 1'b1;
        psel_v = v;
        @(negedge sys_clk_i);
        psel = 1'b0;
        @(negedge sys_clk_i);
    endtask
    initial begin
        seed = 32'hA238;
        for (k = 0; k < 3; k++) boot(k[1:0], 1'b1);
        boot(2'h1, 1'b0);
        sel(2'h1);
        chk(32'(nv_profile_o), 32'h1);
        sel(2'h3);
        chk(32'({nv_profile_o, active_profile_o}), 32'h4);
        power_off_i = 1'b1;
        n = 0;
        repeat (4) begin
            @(negedge sys_clk_i);
            power_off_i = 1'b0;
            n += int'(nv_write_o === 1'b1);
        end
        chk(32'(n), 32'h1);
        $display("profile select done");
        i_udpc_host_model.enumerate(7'h2A, 8'h01);
        repeat (IDL + 5) @(negedge sys_clk_i);
        chk(32'({suspended_o, usb_force_active_o}), 32'h1);
        i_udpc_host_model.hub(1'b1);
        @(negedge sys_clk_i);
        chk(32'(suspended_o), 32'h1);
        i_udpc_host_model.enumerate(7'h11, 8'h02);
        chk(32'({address_o, config_o}), 32'h2A01);
        i_udpc_host_model.hub(1'b0);
        i_udpc_host_model.traffic(1'b1);
        i_udpc_host_model.traffic(1'b0);
        chk(32'({suspended_o, usb_force_active_o}), 32'h1);
        $display("selective suspend done");
        @(negedge sys_clk_i);
        ps_cmd = 1'b1;
        ps_en = 1'b1;
        @(negedge sys_clk_i);
        ps_cmd = 1'b0;
        chk(32'(other_power_save_o), 32'h1);
        n = 0;
        while (suspended_o !== 1'b1 && n < 100) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk(32'(n + 2 == IDL && usb_force_active_o === 1'b0), 32'h1);
        repeat (WW + 2) @(negedge sys_clk_i);
        wake_req = 1'b1;
        @(negedge sys_clk_i);
        wake_req = 1'b0;
        n = int'(remote_wake_o === 1'b1);
        repeat (WC + 10) begin
            @(negedge sys_clk_i);
            n += int'(remote_wake_o === 1'b1);
        end
        chk(32'({n[7:0], suspended_o}), 32'({8'(WC), 1'b0}));
        $display("idle suspend and wake done");
        n = 0;
        while (rx_ready_o === 1'b1 && n < 10) begin
            rx_valid_i = 1'b1;
            rx_data_i = 8'($random(seed));
            q.push_back(rx_data_i);
            @(negedge sys_clk_i);
            n++;
        end
        chk(32'(n), 32'h4);
        for (k = 0; k < 150; k++) begin
            r = $random(seed);
            cmd_ready_i = r[0];
            rx_valid_i = r[1] & (k < 90);
            rx_data_i = r[15:8];
            #1;
            if (rx_valid_i && rx_ready_o === 1'b1) q.push_back(rx_data_i);
            if (cmd_valid_o === 1'b1 && cmd_ready_i && q.size() > 0) chk(32'(cmd_data_o), 32'(q.pop_front()));
            @(negedge sys_clk_i);
        end
        chk(32'({q.size(), cmd_valid_o}), 32'h0);
        $display("stream done");
        i_udpc_host_model.attach(1'b0);
        n = 0;
        while (usb_enable_o === 1'b1 && n < 10) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk(32'(n <= 4 && usb_enable_o === 1'b0), 32'h1);
        repeat (2) @(negedge sys_clk_i);
        chk(32'(address_o), 32'h0);
        $display("detach done");
        report_and_stop;
    end
    initial begin
        #100000;
        n_errors++;
        report_and_stop;
    end
endmodule // testbench
bind udpc_ctrl udpc_ctrl_props #(.WAKE_CYC(WAKE_CYC)) i_udpc_ctrl_props (.sys_clk_i, .reset_i,
    .profile_select_command_i, .power_saving_command_i, .power_saving_enable_i, .wake_request_i,
    .vbus_sense_input_i, .bus_activity_i, .hub_port_disabled_i, .profile_select_value_i,
    .usb_enable_o, .soft_connect_o, .high_speed_o, .device_role_o, .remote_wake_o, .suspended_o,
    .other_power_save_o, .nv_profile_o, .active_profile_o, .product_id_o, .address_o, .config_o);
`default_nettype wire
